// File: tcc_map.svh
// register offsets, field positions and reset values of the timer core
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
// ----------------------------------------------------------------
// byte offsets on the bus
// ----------------------------------------------------------------
`define TCC_OFS_COUNT 8'h00
`define TCC_OFS_CMP_A 8'h04
`define TCC_OFS_CMP_B 8'h08
`define TCC_OFS_CTRL_A 8'h0c
`define TCC_OFS_CTRL_B 8'h10
`define TCC_OFS_FLAG 8'h14
`define TCC_OFS_MASK 8'h18
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCC_CA_WM_LSB 0
`define TCC_CA_COMB_LSB 4
`define TCC_CA_COMA_LSB 6
`define TCC_CB_CS_LSB 0
`define TCC_CB_WM2 3
`define TCC_FLG_OVF 0
`define TCC_FLG_CMA 1
`define TCC_FLG_CMB 2
`define TCC_FLG_USED 8'h07
// ----------------------------------------------------------------
// values and counts
// ----------------------------------------------------------------
`define TCC_RST_BYTE 8'h00
`define TCC_MAX 8'hff
`define TCC_BOTTOM 8'h00
`define TCC_CS_STOP 3'h0
`define TCC_CS_DIV1 3'h1
`define TCC_CS_DIV8 3'h2
`define TCC_CS_DIV64 3'h3
`define TCC_CS_DIV256 3'h4
`define TCC_CS_DIV1024 3'h5
`define TCC_CS_EXT_FALL 3'h6
`define TCC_CS_EXT_RISE 3'h7
`define TCC_PRE_W 10
`endif

// File: tcc_pkg.sv
// types shared by the timer core and its pin synchroniser
`default_nettype none
package tcc_pkg;
  // ----------------------------------------------------------------
  // bus request and waveform modes
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tcc_wb_req_s;

  typedef enum logic [2:0] {
    TCC_NORMAL, TCC_PC_MAX, TCC_CTC, TCC_FAST_MAX,
    TCC_RSVD4, TCC_PC_CMP, TCC_RSVD6, TCC_FAST_CMP
  } tcc_mode_e;

  // ----------------------------------------------------------------
  // module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic level;
    logic rise;
    logic fall;
  } tcc_sync_s;

  typedef struct packed {
    logic [7:0] count;
    logic [1:0][7:0] cmp;
    logic [1:0][7:0] cmp_buf;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] flag;
    logic [7:0] mask;
    logic [9:0] presc;
    logic down;
    logic block;
    logic [1:0] wave;
    logic ack;
    logic [31:0] rdata;
    logic irq;
    logic top;
    logic bottom;
  } tcc_core_s;
endpackage : tcc_pkg
`default_nettype wire

// File: tcc_pin_sync.sv
// three-stage synchroniser and edge finder for the external count pin
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_sync (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pin,
  output logic o_rise,
  output logic o_fall
);
  tcc_pkg::tcc_sync_s st_q;
  tcc_pkg::tcc_sync_s st_d;

  // level accepted once second and third stage agree
  always_comb begin
    st_d = st_q;
    st_d.sync1 = i_pin;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    st_d.rise = 1'b0;
    st_d.fall = 1'b0;
    if (st_q.sync2 == st_q.sync3 && st_q.sync3 != st_q.level) begin // see RULE19
      st_d.level = st_q.sync3;
      st_d.rise = st_q.sync3;
      st_d.fall = ~st_q.sync3;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rise = st_q.rise;
  assign o_fall = st_q.fall;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  chk_single_edge: assert property (o_rise |=> !o_rise) // see RULE19
    else $error("pin edge pulse longer than one cycle");
endmodule : tcc_pin_sync
`default_nettype wire

// File: tcc_core.sv
// eight-bit up/down timer counter with two compare units on wishbone
//
// What this block does
// RULE1: 8-bit count and compares, compared on each tick
// RULE2: overflow, compare A, compare B flags, maskable
// RULE3: tick source select picks prescaler or pin edge
// RULE4: source zero stops the counter entirely
// RULE5: each tick clears, increments or decrements count
// RULE6: bottom at 0x00, maximum is 0xFF
// RULE7: top is 0xFF or compare A, flagged
// RULE8: software reads and writes count anytime
// RULE9: software count write beats clear and count
// RULE10: 3-bit wave mode split over two controls
// RULE11: overflow flag point follows wave mode
// RULE12: compare match sets its unit's flag
// RULE13: compare results drive the wave outputs
// RULE14: flag set on tick after match, W1C
// RULE15: count write blocks match on next tick
// RULE16: mode zero counts up, wraps, flags overflow
// RULE17: mode two clears at compare A match
// RULE18: reset clears all registers to zero; the code loads the bottom indication with one
// RULE19: pin synchronised, one tick per edge
`include "tcc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tcc_core (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  input wire tcc_pkg::tcc_wb_req_s I_WB_REQ,
  input wire logic I_EXT_COUNT_PIN,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_IRQ,
  output logic O_WAVE_OUT_A,
  output logic O_WAVE_OUT_B,
  output logic O_TOP,
  output logic O_BOTTOM
);
  tcc_pkg::tcc_core_s st_q;
  tcc_pkg::tcc_core_s st_d;
  logic ext_rise;
  logic ext_fall;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rd_byte(input tcc_pkg::tcc_core_s s,
                                         input logic [7:0] adr);
    logic [7:0] r;
    r = 8'h00;
    unique case (adr)
      `TCC_OFS_COUNT: r = s.count;
      `TCC_OFS_CMP_A: r = s.cmp_buf[0];
      `TCC_OFS_CMP_B: r = s.cmp_buf[1];
      `TCC_OFS_CTRL_A: r = s.ctrl_a;
      `TCC_OFS_CTRL_B: r = s.ctrl_b;
      `TCC_OFS_FLAG: r = s.flag;
      `TCC_OFS_MASK: r = s.mask;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : rd_byte

  function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                     input logic fast, input logic pc,
                                     input logic hit, input logic wrap,
                                     input logic down);
    logic v;
    v = cur;
    if (fast) begin
      if (com[1] && hit) v = com[0];
      else if (com[1] && wrap) v = ~com[0];
    end else if (pc) begin
      if (com[1] && hit) v = com[0] ^ down;
    end else if (hit) begin
      unique case (com)
        2'h1: v = ~cur;
        2'h2: v = 1'b0;
        2'h3: v = 1'b1;
        2'h0: v = cur;
      endcase
    end
    return v;
  endfunction : wave_next

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  tcc_pin_sync u_pin_sync (
    .i_clk(I_CLK_SYS),
    .i_reset_n(I_RESET_N),
    .i_pin(I_EXT_COUNT_PIN),
    .o_rise(ext_rise),
    .o_fall(ext_fall)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [2:0] cs;
  tcc_pkg::tcc_mode_e mode;
  logic fast;
  logic pc;
  logic tick;
  logic [7:0] top_val;
  logic wb_req;
  logic wb_wr;
  logic wr_cnt;

  always_comb begin
    cs = st_q.ctrl_b[`TCC_CB_CS_LSB +: 3];
    mode = tcc_pkg::tcc_mode_e'({st_q.ctrl_b[`TCC_CB_WM2],
                               st_q.ctrl_a[`TCC_CA_WM_LSB +: 2]}); // see RULE10
    fast = (mode == tcc_pkg::TCC_FAST_MAX) || (mode == tcc_pkg::TCC_FAST_CMP);
    pc = (mode == tcc_pkg::TCC_PC_MAX) || (mode == tcc_pkg::TCC_PC_CMP);
    unique case (cs) // see RULE3
      `TCC_CS_STOP: tick = 1'b0; // see RULE4
      `TCC_CS_DIV1: tick = 1'b1;
      `TCC_CS_DIV8: tick = &st_q.presc[2:0];
      `TCC_CS_DIV64: tick = &st_q.presc[5:0];
      `TCC_CS_DIV256: tick = &st_q.presc[7:0];
      `TCC_CS_DIV1024: tick = &st_q.presc[9:0];
      `TCC_CS_EXT_FALL: tick = ext_fall; // see RULE19
      `TCC_CS_EXT_RISE: tick = ext_rise;
    endcase
    if (mode == tcc_pkg::TCC_CTC || mode == tcc_pkg::TCC_PC_CMP ||
        mode == tcc_pkg::TCC_FAST_CMP) begin
      top_val = st_q.cmp[0]; // see RULE7
    end else begin
      top_val = `TCC_MAX; // see RULE6
    end
    wb_req = I_WB_REQ.cyc && I_WB_REQ.stb;
    wb_wr = wb_req && I_WB_REQ.we && I_WB_REQ.sel[0] && st_q.ack;
    wr_cnt = wb_wr && (I_WB_REQ.adr == `TCC_OFS_COUNT);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [1:0] hit;
  logic ovf;
  logic at_top;
  logic [7:0] wbyte;

  always_comb begin
    st_d = st_q;
    hit = 2'b00;
    ovf = 1'b0;
    at_top = (st_q.count == top_val);
    wbyte = I_WB_REQ.dat[7:0];
    st_d.presc = st_q.presc + 10'h001;
    // counting sequence per wave mode
    if (tick) begin // see RULE5
      for (int u = 0; u < 2; u++) begin
        hit[u] = (st_q.count == st_q.cmp[u]) && !st_q.block; // see RULE1
      end
      st_d.block = 1'b0;
      if (pc) begin
        if (!st_q.down && at_top) begin
          st_d.down = 1'b1;
          st_d.count = st_q.count - 8'h01;
        end else if (st_q.down && st_q.count == `TCC_BOTTOM) begin
          st_d.down = 1'b0;
          st_d.count = st_q.count + 8'h01;
          ovf = 1'b1; // see RULE11
        end else if (st_q.down) begin
          st_d.count = st_q.count - 8'h01;
        end else begin
          st_d.count = st_q.count + 8'h01;
        end
      end else if (mode == tcc_pkg::TCC_CTC || fast) begin
        st_d.down = 1'b0;
        st_d.count = at_top ? `TCC_BOTTOM : st_q.count + 8'h01; // see RULE17
        ovf = fast ? at_top : (st_q.count == `TCC_MAX); // see RULE11
      end else begin
        st_d.down = 1'b0;
        st_d.count = st_q.count + 8'h01; // see RULE16
        ovf = (st_q.count == `TCC_MAX);
      end
      // double-buffered compares load at top in pwm modes
      if ((fast || pc) && at_top) begin
        st_d.cmp = st_q.cmp_buf;
      end
      for (int u = 0; u < 2; u++) begin
        st_d.wave[u] = wave_next(st_q.wave[u],
          st_q.ctrl_a[(u == 0 ? `TCC_CA_COMA_LSB : `TCC_CA_COMB_LSB) +: 2],
          fast, pc, hit[u], at_top, st_q.down); // see RULE13
      end
    end
    if (!(fast || pc)) begin
      st_d.cmp = st_q.cmp_buf;
    end
    // register writes, taken at the edge that sees ack high
    if (wb_wr) begin
      unique case (I_WB_REQ.adr)
        `TCC_OFS_COUNT: begin
          st_d.count = wbyte; // see RULE8 RULE9
          st_d.block = 1'b1; // see RULE15
        end
        `TCC_OFS_CMP_A: st_d.cmp_buf[0] = wbyte;
        `TCC_OFS_CMP_B: st_d.cmp_buf[1] = wbyte;
        `TCC_OFS_CTRL_A: st_d.ctrl_a = wbyte;
        `TCC_OFS_CTRL_B: st_d.ctrl_b = wbyte & 8'h0f;
        `TCC_OFS_FLAG: st_d.flag = st_q.flag & ~wbyte; // see RULE14
        `TCC_OFS_MASK: st_d.mask = wbyte & `TCC_FLG_USED;
        default: st_d.count = st_d.count;
      endcase
    end
    // events set after the clear so a same-cycle set wins
    if (ovf) st_d.flag[`TCC_FLG_OVF] = 1'b1; // see RULE2
    if (hit[0]) st_d.flag[`TCC_FLG_CMA] = 1'b1; // see RULE12 RULE14
    if (hit[1]) st_d.flag[`TCC_FLG_CMB] = 1'b1;
    st_d.irq = |(st_d.flag & st_d.mask); // see RULE2
    st_d.top = (st_d.count == top_val);
    st_d.bottom = (st_d.count == `TCC_BOTTOM); // see RULE6
    st_d.ack = wb_req && !st_q.ack;
    st_d.rdata = {24'h000000, rd_byte(st_q, I_WB_REQ.adr)};
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      st_q <= '0; // see RULE18
      st_q.bottom <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign O_WB_DAT = st_q.rdata;
  assign O_WB_ACK = st_q.ack;
  assign O_IRQ = st_q.irq;
  assign O_WAVE_OUT_A = st_q.wave[0];
  assign O_WAVE_OUT_B = st_q.wave[1];
  assign O_TOP = st_q.top;
  assign O_BOTTOM = st_q.bottom;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);

  chk_stop_holds: assert property ((cs == `TCC_CS_STOP) && !wr_cnt // see RULE4
    |=> $stable(st_q.count))
    else $error("count moved with no tick source");
  chk_write_wins: assert property (wr_cnt // see RULE9
    |=> st_q.count == $past(I_WB_REQ.dat[7:0]))
    else $error("count write lost to counting");
  chk_irq_level: assert property (O_IRQ == |(st_q.flag & st_q.mask)) // see RULE2
    else $error("interrupt does not follow masked flags");
  chk_normal_wrap: assert property (tick && !wr_cnt && // see RULE16
    mode == tcc_pkg::TCC_NORMAL && st_q.count == `TCC_MAX
    |=> st_q.count == `TCC_BOTTOM && st_q.flag[`TCC_FLG_OVF])
    else $error("normal mode wrap or overflow wrong");
  chk_ctc_clear: assert property (tick && !wr_cnt && // see RULE17
    mode == tcc_pkg::TCC_CTC && st_q.count == st_q.cmp[0]
    |=> st_q.count == `TCC_BOTTOM)
    else $error("clear on compare A missing");
  chk_match_flag: assert property (tick && !st_q.block && // see RULE14
    st_q.count == st_q.cmp[1] |=> st_q.flag[`TCC_FLG_CMB])
    else $error("compare B flag not set");
  chk_block_hold: assert property (st_q.block && !tick // see RULE15
    |=> st_q.block)
    else $error("match block dropped before a tick");
  chk_block_flag: assert property (st_q.block && tick && // see RULE15
    !st_q.flag[`TCC_FLG_CMA] && !(wb_wr && I_WB_REQ.adr == `TCC_OFS_FLAG)
    |=> !st_q.flag[`TCC_FLG_CMA])
    else $error("blocked match set a flag");
  chk_bottom_ind: assert property (O_BOTTOM == (st_q.count == `TCC_BOTTOM)) // see RULE6
    else $error("bottom indication wrong");
  chk_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK) // see RULE8
    else $error("ack longer than one cycle");

  // pwm counting sequences
  chk_fast_top: assert property (tick && !wr_cnt && fast && // see RULE7
    at_top |=> st_q.count == `TCC_BOTTOM && st_q.flag[`TCC_FLG_OVF])
    else $error("fast mode did not restart at top");
  chk_pc_turn: assert property (tick && !wr_cnt && pc && // see RULE5
    at_top && !st_q.down
    |=> st_q.down && st_q.count == $past(st_q.count) - 8'h01)
    else $error("phase correct count did not turn at top");
  chk_pc_bottom: assert property (tick && !wr_cnt && pc && // see RULE11
    st_q.down && st_q.count == `TCC_BOTTOM
    |=> !st_q.down && st_q.flag[`TCC_FLG_OVF])
    else $error("phase correct turn at bottom wrong");

  // write one to clear
  chk_flag_clear: assert property (wb_wr && !ovf && // see RULE14
    I_WB_REQ.adr == `TCC_OFS_FLAG && I_WB_REQ.dat[`TCC_FLG_OVF]
    |=> !st_q.flag[`TCC_FLG_OVF])
    else $error("overflow flag not cleared by writing one");

  // main scenarios
  cov_overflow: cover property (tick && ovf);
  cov_match_a: cover property (tick && hit[0]);
  cov_ext_tick: cover property (cs == `TCC_CS_EXT_RISE && tick);
  cov_pc_turn: cover property (pc && tick && at_top && !st_q.down);
  cov_fast_wrap: cover property (fast && tick && at_top);
endmodule : tcc_core
`default_nettype wire

// File: tcc_core_tb.sv
// self-checking testbench for the timer counter core
`include "tcc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tcc_core_tb;
  // ----------------------------------------------------------------
  // clock, stimulus and design
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin = 1'b0;
  tcc_pkg::tcc_wb_req_s req = '0;
  logic [31:0] wb_dat;
  logic wb_ack, irq, wave_a, wave_b, top, bottom;
  logic [31:0] rd;
  int mismatches = 0;
  int checked = 0;
  logic [7:0] ofs [8] = '{`TCC_OFS_COUNT, `TCC_OFS_CMP_A, `TCC_OFS_CMP_B,
    `TCC_OFS_CTRL_A, `TCC_OFS_CTRL_B, `TCC_OFS_FLAG, `TCC_OFS_MASK, 8'h1c};
  logic [7:0] rbk [8] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h00, 8'h07,
    8'h00};
  int wt [5] = '{128, 1024, 8192, 32768, 2048};
  int dv [5] = '{1, 8, 64, 256, 1024};

  always #2.5 clk = ~clk;

  tcc_core i_dut (
    .I_CLK_SYS(clk),
    .I_RESET_N(rst_n),
    .I_WB_REQ(req),
    .I_EXT_COUNT_PIN(pin),
    .O_WB_DAT(wb_dat),
    .O_WB_ACK(wb_ack),
    .O_IRQ(irq),
    .O_WAVE_OUT_A(wave_a),
    .O_WAVE_OUT_B(wave_b),
    .O_TOP(top),
    .O_BOTTOM(bottom)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // count after a free-running prescaler, phase unknown
  task automatic near(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if ($isunknown(got) || got > exp + 32'd6 || got + 32'd6 < exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : near

  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [7:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel,
             dat: {24'h0, dat}};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_dat;
    req <= '0;
    if (n >= 20) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      end_sim();
    end
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat, 4'h1);
  endtask : wr

  task automatic rchk(input logic [7:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00, 4'h1);
    cmp(rd, {24'h0, exp});
  endtask : rchk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // one rising and one falling pin edge per pulse
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge clk);
      pin <= 1'b1;
      idle(4);
      pin <= 1'b0;
      idle(3);
    end
    idle(8);
  endtask : edges

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    idle(12);
    rst_n <= 1'b1;
    idle(2);
    for (int i = 0; i < 8; i++) rchk(ofs[i], 8'h00);
    cmp({26'h0, bottom, top, irq, wave_a, wave_b, 1'b0}, 32'h20);
    $display("test reset done");
    for (int i = 0; i < 8; i++) wr(ofs[i], 8'hff);
    for (int i = 1; i < 8; i++) rchk(ofs[i], rbk[i]);
    bus(1'b1, `TCC_OFS_CMP_A, 8'h12, 4'he);
    rchk(`TCC_OFS_CMP_A, 8'hff);
    for (int i = 0; i < 7; i++) wr(ofs[i], 8'h00);
    $display("test registers done");
    wr(`TCC_OFS_COUNT, 8'hff);
    idle(20);
    rchk(`TCC_OFS_COUNT, 8'hff);
    cmp({30'h0, top, bottom}, 32'h2);
    $display("test stopped done");
    wr(`TCC_OFS_COUNT, 8'hfd);
    wr(`TCC_OFS_CMP_A, 8'hfe);
    wr(`TCC_OFS_CMP_B, 8'h40);
    wr(`TCC_OFS_CTRL_B, 8'(`TCC_CS_EXT_RISE));
    edges(3);
    rchk(`TCC_OFS_COUNT, 8'h00);
    rchk(`TCC_OFS_FLAG, 8'h03);
    cmp({31'h0, bottom}, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    wr(`TCC_OFS_MASK, 8'h01);
    idle(3);
    cmp({31'h0, irq}, 32'h1);
    wr(`TCC_OFS_FLAG, 8'h01);
    idle(3);
    cmp({31'h0, irq}, 32'h0);
    rchk(`TCC_OFS_FLAG, 8'h02);
    wr(`TCC_OFS_MASK, 8'h03);
    idle(3);
    cmp({31'h0, irq}, 32'h1);
    wr(`TCC_OFS_FLAG, 8'h02);
    wr(`TCC_OFS_MASK, 8'h00);
    $display("test overflow done");
    wr(`TCC_OFS_CTRL_B, 8'(`TCC_CS_EXT_FALL));
    wr(`TCC_OFS_COUNT, 8'h10);
    @(posedge clk);
    pin <= 1'b1;
    idle(10);
    rchk(`TCC_OFS_COUNT, 8'h10);
    pin <= 1'b0;
    idle(10);
    rchk(`TCC_OFS_COUNT, 8'h11);
    $display("test pin edge done");
    wr(`TCC_OFS_CTRL_B, 8'(`TCC_CS_STOP));
    wr(`TCC_OFS_CMP_B, 8'h20);
    wr(`TCC_OFS_COUNT, 8'h20);
    wr(`TCC_OFS_FLAG, 8'h07);
    wr(`TCC_OFS_CTRL_B, 8'(`TCC_CS_EXT_RISE));
    edges(1);
    rchk(`TCC_OFS_COUNT, 8'h21);
    rchk(`TCC_OFS_FLAG, 8'h00);
    wr(`TCC_OFS_COUNT, 8'h1f);
    edges(2);
    rchk(`TCC_OFS_FLAG, 8'h04);
    $display("test blocking done");
    wr(`TCC_OFS_CTRL_B, 8'(`TCC_CS_STOP));
    wr(`TCC_OFS_CTRL_A, 8'h72);
    wr(`TCC_OFS_CMP_A, 8'h03);
    wr(`TCC_OFS_CMP_B, 8'h01);
    wr(`TCC_OFS_COUNT, 8'h00);
    wr(`TCC_OFS_FLAG, 8'h07);
    wr(`TCC_OFS_CTRL_B, 8'(`TCC_CS_EXT_RISE));
    edges(5);
    rchk(`TCC_OFS_COUNT, 8'h01);
    rchk(`TCC_OFS_FLAG, 8'h06);
    cmp({30'h0, wave_a, wave_b}, 32'h3);
    $display("test clear on match done");
    wr(`TCC_OFS_CTRL_A, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(`TCC_OFS_CTRL_B, 8'(`TCC_CS_STOP));
      wr(`TCC_OFS_COUNT, 8'h00);
      wr(`TCC_OFS_CTRL_B, 8'(i + 1));
      idle(wt[i]);
      wr(`TCC_OFS_CTRL_B, 8'(`TCC_CS_STOP));
      bus(1'b0, `TCC_OFS_COUNT, 8'h00, 4'h1);
      near(rd, 32'(wt[i] / dv[i]));
    end
    $display("test prescaler done");
    wr(`TCC_OFS_CMP_A, 8'h04);
    wr(`TCC_OFS_CMP_B, 8'h02);
    wr(`TCC_OFS_COUNT, 8'h00);
    wr(`TCC_OFS_FLAG, 8'h07);
    wr(`TCC_OFS_CTRL_A, 8'ha3);
    wr(`TCC_OFS_CTRL_B, 8'h0f);
    edges(5);
    rchk(`TCC_OFS_COUNT, 8'h00);
    rchk(`TCC_OFS_FLAG, 8'h07);
    cmp({30'h0, wave_a, wave_b}, 32'h1);
    $display("test fast pwm done");
    wr(`TCC_OFS_CTRL_B, 8'h08);
    wr(`TCC_OFS_COUNT, 8'h00);
    wr(`TCC_OFS_FLAG, 8'h07);
    wr(`TCC_OFS_CTRL_A, 8'h01);
    wr(`TCC_OFS_CTRL_B, 8'h0f);
    edges(8);
    rchk(`TCC_OFS_COUNT, 8'h00);
    rchk(`TCC_OFS_FLAG, 8'h06);
    edges(1);
    rchk(`TCC_OFS_FLAG, 8'h07);
    $display("test phase correct done");
    end_sim();
  end
endmodule : tcc_core_tb
`default_nettype wire
